// ===== inc/ccd_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Shared constants and types of the cache and DRAM controller
////////////////////////////////////////////////////////////////////////
package ccd_pkg;
  // Timing
  localparam int CLK_NS  = 50;               // Clock period in ns
  localparam int REF_NS  = 15600;            // Refresh interval in ns
  localparam int REF_CYC = REF_NS / CLK_NS;  // Refresh tick, rounded down
  localparam logic [3:0] REF_MAX = 4'h8;     // Pending count forcing refresh
  // Cache geometry
  localparam int CACHE_BYTES = 8192;         // Unified store size
  localparam int WAYS = 2;                   // Ways per set
  localparam int SETS = CACHE_BYTES / (WAYS * 4);
  localparam int IDXW = 10;                  // Set index bits
  localparam int TAGW = 12;                  // Tag bits
  localparam int AW   = 23;                  // Word address, 32 MB
  localparam int MAW  = 11;                  // DRAM address pins
  localparam int CACHE_BIT = 22;             // Set above 16 MB
  // ROM region decode, 128 KB blocks on word bits 21..15
  localparam int BLK_HI = 21;
  localparam int BLK_LO = 15;
  localparam logic [6:0] VID_BLK = 7'h06;    // Video BIOS block
  localparam logic [6:0] SYS_BLK = 7'h07;    // System BIOS block
  // Non-cacheable compare on 64 KB granules
  localparam int NC_HI = 21;
  localparam int NC_LO = 14;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NC0  = 8'h04;
  localparam logic [7:0] REG_NC1  = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  // Control fields
  localparam int CTRL_CEN = 0;               // Cache enable
  localparam int CTRL_HID = 1;               // Hidden refresh enable
  localparam int CTRL_SHS = 2;               // Shadow system BIOS
  localparam int CTRL_SHV = 3;               // Shadow video BIOS
  localparam int CTRL_WS  = 4;               // Wait states, 4 bits
  // Region fields
  localparam int NC_BASE = 0;
  localparam int NC_MASK = 8;
  localparam int NC_EN   = 16;
  // Bank size codes
  localparam logic [1:0] SZ_NONE = 2'h0;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [16:0] NC_RST   = 17'h00000;
  localparam logic [3:0]  BANK_RST = 4'h1;
  // Main sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WB = 3'b001, ST_FILL = 3'b010,
    ST_DIRECT = 3'b011, ST_ROM = 3'b100
  } ccd_state_t;
  // DRAM sequencer states
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_PRE = 3'b001, D_RAS = 3'b010,
    D_CAS = 3'b011, D_REF = 3'b100
  } ccd_dstate_t;
endpackage
`default_nettype wire

// ===== inc/ccd_mem_if.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Request path from cache control to the DRAM sequencer
////////////////////////////////////////////////////////////////////////
interface ccd_mem_if;
  import ccd_pkg::*;
  logic          req;      // Held until done
  logic          we;       // Write request
  logic [AW-1:0] addr;     // Word address
  logic [3:0]    be;       // Byte enables
  logic [31:0]   wdata;    // Write data
  logic [31:0]   rdata;    // Read data, valid with done
  logic          done;     // One-cycle completion
  logic [3:0]    ws;       // Wait states
  logic          hidEn;    // Hidden refresh enable
  logic [3:0]    bankCfg;  // Bank size codes
  logic [3:0]    refPend;  // Deferred refresh count
  modport ctl (output req, we, addr, be, wdata, ws, hidEn, bankCfg,
               input rdata, done, refPend);
  modport seq (input req, we, addr, be, wdata, ws, hidEn, bankCfg,
               output rdata, done, refPend);
endinterface
`default_nettype wire

// ===== src/ccd_way.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////
// One cache way: tag, data, valid and dirty per set
////////////////////////////////////////////////////////////////////////
module ccd_way import ccd_pkg::*; #(
  parameter int IW = IDXW,
  parameter int TW = TAGW
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [IW-1:0] idx,
  input  wire logic          wrEn,
  input  wire logic [TW-1:0] wrTag,
  input  wire logic [31:0]   wrData,
  input  wire logic [3:0]    wrBe,
  input  wire logic          wrDirty,
  output logic               rdValid,
  output logic               rdDirty,
  output logic [TW-1:0]      rdTag,
  output logic [31:0]        rdData
);
  logic [TW-1:0]    tagMem [2**IW];  // Tags
  logic [31:0]      dataMem [2**IW]; // Line data
  logic [2**IW-1:0] validMem;        // Valid flags
  logic [2**IW-1:0] dirtyMem;        // Modified flags

  // Lookup reads are combinational so a hit answers at once
  assign rdValid = validMem[idx];
  assign rdDirty = dirtyMem[idx];
  assign rdTag   = tagMem[idx];
  assign rdData  = dataMem[idx];

  // [RL13] Flags cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      validMem <= '0;
      dirtyMem <= '0;
    end else if (wrEn) begin
      validMem[idx] <= 1'b1;
      dirtyMem[idx] <= wrDirty;
    end
  end

  // Store tag and enabled bytes
  always_ff @(posedge clk) begin
    if (wrEn) begin
      tagMem[idx] <= wrTag;
      for (int b = 0; b < 4; b++) begin
        if (wrBe[b]) begin
          dataMem[idx][8*b +: 8] <= wrData[8*b +: 8];
        end
      end
    end
  end
endmodule // ccd_way
`default_nettype wire

// ===== src/ccd_dram_seq.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Page-mode DRAM sequencer with deferred refresh
////////////////////////////////////////////////////////////////////////
module ccd_dram_seq import ccd_pkg::*; (
  input  wire logic           clk,
  input  wire logic           rst_b,
  ccd_mem_if.seq              m,
  output logic [1:0]          rasB,
  output logic [3:0]          casB,
  output logic                weB,
  output logic [MAW-1:0]      ma,
  output logic [31:0]         dqOut,
  output logic                dqOeB,
  input  wire logic [31:0]    dqIn
);
  typedef struct packed {
    ccd_dstate_t    st;
    logic           rowOpen;
    logic           openBank;
    logic [MAW-1:0] openRow;
    logic [3:0]     wcnt;
    logic [8:0]     refCnt;
    logic [3:0]     pend;
    logic [1:0]     rasB;
    logic [3:0]     casB;
    logic           weB;
    logic [MAW-1:0] ma;
    logic [31:0]    dqOut;
    logic           dqOeB;
    logic           done;
    logic [31:0]    rdata;
  } ccd_dram_t;

  ccd_dram_t      r, n;      // State and next
  logic [AW-1:0]  b0Words;   // Bank 0 size in words
  logic [AW-1:0]  offs;      // Offset in bank
  logic [1:0]     sz;        // Size code of bank
  logic           bank;      // Selected bank
  logic [MAW-1:0] rowA;      // Row address
  logic [MAW-1:0] colA;      // Column address
  logic           tick;      // Refresh interval over
  logic           needRef;   // Refresh to run now
  logic           goRas;     // Open a row
  logic           goCas;     // Issue a column cycle
  logic           decPend;   // Refresh finished

  // [RL10] Bank split and row/column by module size
  always_comb begin
    b0Words = (m.bankCfg[1:0] == SZ_NONE) ? '0
            : AW'(1) << (16 + 2 * int'(m.bankCfg[1:0]));
    bank = (m.addr >= b0Words);
    offs = bank ? AW'(m.addr - b0Words) : m.addr;
    sz   = bank ? m.bankCfg[3:2] : m.bankCfg[1:0];
    colA = MAW'(offs & AW'((AW'(1) << (8 + int'(sz))) - AW'(1)));
    rowA = MAW'(offs >> (8 + int'(sz)));
  end

  // Next-state logic
  always_comb begin
    n = r;
    n.done = 1'b0;
    goRas = 1'b0;
    goCas = 1'b0;
    decPend = 1'b0;
    tick = (r.refCnt == 9'(REF_CYC - 1));
    n.refCnt = tick ? 9'h000 : r.refCnt + 9'h001;
    // [RL12] Defer refresh while a request waits
    // [RL14] Limit reached forces the stall
    needRef = (r.pend != 4'h0)
            && (!m.hidEn || !m.req || r.done || r.pend >= REF_MAX);
    case (r.st)
      D_IDLE: begin
        if (needRef) begin
          // Column before row refresh, pages closed
          n.rasB = 2'b11;
          n.casB = 4'h0;
          n.rowOpen = 1'b0;
          n.wcnt = 4'h1;
          n.st = D_REF;
        end else if (m.req && !r.done) begin
          // [RL8] Open page goes straight to column
          if (r.rowOpen && r.openBank == bank && r.openRow == rowA) begin
            goCas = 1'b1;
          end else if (r.rowOpen) begin
            n.rasB = 2'b11;
            n.rowOpen = 1'b0;
            n.st = D_PRE;
          end else begin
            goRas = 1'b1;
          end
        end
      end
      D_PRE: goRas = 1'b1;
      D_RAS: begin
        // [RL9] Wait states after row open
        if (r.wcnt == 4'h0) begin
          goCas = 1'b1;
        end else begin
          n.wcnt = r.wcnt - 4'h1;
        end
      end
      D_CAS: begin
        n.rdata = dqIn;
        n.done = 1'b1;
        n.casB = 4'hF;
        n.weB = 1'b1;
        n.dqOeB = 1'b1;
        n.st = D_IDLE;
      end
      D_REF: begin
        if (r.wcnt != 4'h0) begin
          n.rasB = 2'b00;
          n.wcnt = 4'h0;
        end else begin
          n.rasB = 2'b11;
          n.casB = 4'hF;
          decPend = 1'b1;
          n.st = D_IDLE;
        end
      end
      default: n.st = D_IDLE;
    endcase
    if (goRas) begin
      n.ma = rowA;
      n.rasB = bank ? 2'b01 : 2'b10;
      n.rowOpen = 1'b1;
      n.openBank = bank;
      n.openRow = rowA;
      n.wcnt = m.ws;
      n.st = D_RAS;
    end
    if (goCas) begin
      n.ma = colA;
      n.casB = m.we ? ~m.be : 4'h0;
      n.weB = ~m.we;
      n.dqOut = m.wdata;
      n.dqOeB = ~m.we;
      n.st = D_CAS;
    end
    // [RL14] Count deferred refreshes
    if (tick && !decPend && r.pend != 4'hF) begin
      n.pend = r.pend + 4'h1;
    end else if (decPend && !tick) begin
      n.pend = r.pend - 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= D_IDLE;
      r.rasB <= 2'b11;
      r.casB <= 4'hF;
      r.weB <= 1'b1;
      r.dqOeB <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign m.rdata = r.rdata;
  assign m.done = r.done;
  assign m.refPend = r.pend;
  assign rasB = r.rasB;
  assign casB = r.casB;
  assign weB = r.weB;
  assign ma = r.ma;
  assign dqOut = r.dqOut;
  assign dqOeB = r.dqOeB;
endmodule // ccd_dram_seq
`default_nettype wire

// ===== src/ccd_cache_ctrl.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RL1] 8 KB unified cache, 16 MB cacheable
// [RL2] Two-way set associative lookup
// [RL3] Two non-cacheable regions bypass cache
// [RL4] Write hit updates cache only, one cycle
// [RL5] Dirty data written back only on refill
// [RL6] Read hit answered with no wait
// [RL7] Cache and memory control run concurrently
// [RL8] Page mode, open page needs no waits
// [RL9] One programmable wait-state setting
// [RL10] Two banks, 256K/1M/4M SIMMs, 32 MB
// [RL11] Shadowing serves BIOS regions from DRAM
// [RL12] Hidden refresh defers while memory busy
// [RL13] Valid, dirty flags, LRU replacement
// [RL14] Pending refresh limit forces stall
// [RL15] Write miss to memory, no allocate
////////////////////////////////////////////////////////////////////////
module ccd_cache_ctrl import ccd_pkg::*; (
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Processor side
  input  wire logic          cpuReq,
  input  wire logic          cpuWe,
  input  wire logic [AW-1:0] cpuAddr,
  input  wire logic [3:0]    cpuBe,
  input  wire logic [31:0]   cpuWdata,
  output logic [31:0]        cpuRdata,
  output logic               cpuReady,
  // ROM side
  output logic               romSel,
  input  wire logic          romDone,
  input  wire logic [31:0]   romRdata,
  // Register port
  input  wire logic [7:0]    regAddr,
  input  wire logic [31:0]   regWdata,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic [31:0]        regRdata,
  // DRAM pins
  output logic [1:0]         rasB,
  output logic [3:0]         casB,
  output logic               weB,
  output logic [MAW-1:0]     ma,
  output logic [31:0]        dqOut,
  output logic               dqOeB,
  input  wire logic [31:0]   dqIn
);
  ////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ccd_state_t    st;        // Sequencer state
    logic          ready;     // Processor answer
    logic [31:0]   rdata;     // Processor read data
    logic          romSel;    // ROM cycle active
    logic [31:0]   regRdata;  // Register read data
    logic [7:0]    ctrl;      // Control register
    logic [16:0]   nc0;       // Region 0
    logic [16:0]   nc1;       // Region 1
    logic [3:0]    bank;      // Bank sizes
    logic          memReq;    // Memory request held
    logic          memWe;     // Memory write
    logic [AW-1:0] memAddr;   // Memory address
    logic [3:0]    memBe;     // Memory byte enables
    logic [31:0]   memWdata;  // Memory write data
    logic          fillWay;   // Way being refilled
  } ccd_main_t;

  ccd_main_t       r, n;      // State and next
  ccd_mem_if       mif ();    // Memory request path

  logic [IDXW-1:0] idx;       // Set index
  logic [TAGW-1:0] tag;       // Address tag
  logic [1:0]      vld;       // Way valid
  logic [1:0]      drt;       // Way dirty
  logic [TAGW-1:0] wtag [2];  // Way tags
  logic [31:0]     wdat [2];  // Way data
  logic [1:0]      hit;       // Way hit
  logic [1:0]      wEn;       // Way write enables
  logic [TAGW-1:0] wrTag;     // Tag to store
  logic [31:0]     wrData;    // Data to store
  logic [3:0]      wrBe;      // Bytes to store
  logic            wrDirty;   // Dirty flag to store
  logic [SETS-1:0] lruMem;    // Least recent way per set
  logic            lruWr;     // Update LRU bit
  logic            lruVal;    // New LRU way
  logic            vict;      // Victim way
  logic [6:0]      blk;       // 128 KB block
  logic            romAcc;    // Access goes to ROM
  logic            ncHit0;    // In region 0
  logic            ncHit1;    // In region 1
  logic            cacheable; // Access may use cache

  ////////////////////////////////////////////////////////////////////
  // Cache store
  ////////////////////////////////////////////////////////////////////
  // [RL2] Two ways searched side by side
  for (genvar w = 0; w < WAYS; w++) begin : g_way
    ccd_way u_way (
      .clk     (clk),
      .rst_b   (rst_b),
      .idx     (idx),
      .wrEn    (wEn[w]),
      .wrTag   (wrTag),
      .wrData  (wrData),
      .wrBe    (wrBe),
      .wrDirty (wrDirty),
      .rdValid (vld[w]),
      .rdDirty (drt[w]),
      .rdTag   (wtag[w]),
      .rdData  (wdat[w])
    );
  end

  // LRU bits need no reset: an invalid way is always
  // taken first, so a stale bit is never consulted
  always_ff @(posedge clk) begin
    if (lruWr) begin
      lruMem[idx] <= lruVal;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // DRAM sequencer
  ////////////////////////////////////////////////////////////////////
  ccd_dram_seq u_dram (
    .clk   (clk),
    .rst_b (rst_b),
    .m     (mif),
    .rasB  (rasB),
    .casB  (casB),
    .weB   (weB),
    .ma    (ma),
    .dqOut (dqOut),
    .dqOeB (dqOeB),
    .dqIn  (dqIn)
  );

  assign mif.req = r.memReq;
  assign mif.we = r.memWe;
  assign mif.addr = r.memAddr;
  assign mif.be = r.memBe;
  assign mif.wdata = r.memWdata;
  // [RL9] One wait setting for both banks
  assign mif.ws = r.ctrl[CTRL_WS +: 4];
  assign mif.hidEn = r.ctrl[CTRL_HID];
  assign mif.bankCfg = r.bank;

  ////////////////////////////////////////////////////////////////////
  // Address decode
  ////////////////////////////////////////////////////////////////////
  always_comb begin
    idx = cpuAddr[IDXW-1:0];
    tag = cpuAddr[IDXW +: TAGW];
    // [RL13] Hit needs valid line and equal tag
    for (int w = 0; w < WAYS; w++) begin
      hit[w] = vld[w] && (wtag[w] == tag);
    end
    // [RL13] Empty way first, else least recent
    vict = vld[0] ? (vld[1] ? lruMem[idx] : 1'b1) : 1'b0;
    blk = cpuAddr[BLK_HI:BLK_LO];
    // [RL11] Unshadowed BIOS blocks go to ROM
    romAcc = !cpuAddr[CACHE_BIT]
           && ((blk == VID_BLK && !r.ctrl[CTRL_SHV])
            || (blk == SYS_BLK && !r.ctrl[CTRL_SHS]));
    // [RL3] Base and mask compare per region
    ncHit0 = r.nc0[NC_EN] && (((cpuAddr[NC_HI:NC_LO]
           ^ r.nc0[NC_BASE +: 8]) & r.nc0[NC_MASK +: 8]) == 8'h00);
    ncHit1 = r.nc1[NC_EN] && (((cpuAddr[NC_HI:NC_LO]
           ^ r.nc1[NC_BASE +: 8]) & r.nc1[NC_MASK +: 8]) == 8'h00);
    // [RL1] Only the low 16 MB is cached
    cacheable = r.ctrl[CTRL_CEN] && !cpuAddr[CACHE_BIT]
              && !ncHit0 && !ncHit1;
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer and registers
  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.ready = 1'b0;
    n.regRdata = 32'h0000_0000;
    wEn = 2'b00;
    wrTag = tag;
    wrData = cpuWdata;
    wrBe = cpuBe;
    wrDirty = 1'b0;
    lruWr = 1'b0;
    lruVal = 1'b0;
    // Request retires on completion
    if (mif.done) begin
      n.memReq = 1'b0;
    end
    case (r.st)
      ST_IDLE: begin
        // Ready high means the request is already answered
        if (cpuReq && !r.ready) begin
          if (romAcc) begin
            n.romSel = 1'b1;
            n.st = ST_ROM;
          end else if (cacheable && hit != 2'b00) begin
            lruWr = 1'b1;
            lruVal = hit[0];
            n.ready = 1'b1;
            if (cpuWe) begin
              // [RL4] Write hit stays in cache
              wEn = hit;
              wrDirty = 1'b1;
            end else begin
              // [RL6] Read hit answered next edge
              n.rdata = hit[1] ? wdat[1] : wdat[0];
            end
          end else if (!r.memReq) begin
            n.memWe = cpuWe;
            n.memAddr = cpuAddr;
            n.memBe = cpuBe;
            n.memWdata = cpuWdata;
            n.memReq = 1'b1;
            if (cpuWe) begin
              // [RL15] Posted write, no line taken
              // [RL7] Hits go on while it drains
              n.ready = 1'b1;
            end else if (cacheable) begin
              n.fillWay = vict;
              n.st = ST_FILL;
              // [RL5] Dirty victim copied out first
              if (vld[vict] && drt[vict]) begin
                n.memWe = 1'b1;
                n.memAddr = {cpuAddr[AW-1], wtag[vict], idx};
                n.memBe = 4'hF;
                n.memWdata = wdat[vict];
                n.st = ST_WB;
              end
            end else begin
              n.st = ST_DIRECT;
            end
          end
        end
      end
      ST_WB: begin
        // Refill read follows the write-back
        if (mif.done) begin
          n.memReq = 1'b1;
          n.memWe = 1'b0;
          n.memAddr = cpuAddr;
          n.st = ST_FILL;
        end
      end
      ST_FILL: begin
        if (mif.done) begin
          // [RL13] Fill victim clean, other way now LRU
          wEn = r.fillWay ? 2'b10 : 2'b01;
          wrData = mif.rdata;
          wrBe = 4'hF;
          lruWr = 1'b1;
          lruVal = ~r.fillWay;
          n.rdata = mif.rdata;
          n.ready = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_DIRECT: begin
        // Uncached read passes memory data through
        if (mif.done) begin
          n.rdata = mif.rdata;
          n.ready = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_ROM: begin
        if (romDone) begin
          n.romSel = 1'b0;
          n.rdata = romRdata;
          n.ready = 1'b1;
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // Register writes
    if (regWr) begin
      case (regAddr)
        REG_CTRL: n.ctrl = regWdata[7:0];
        REG_NC0:  n.nc0 = regWdata[16:0];
        REG_NC1:  n.nc1 = regWdata[16:0];
        REG_BANK: n.bank = regWdata[3:0];
        default:  n.ctrl = r.ctrl;
      endcase
    end
    // Register reads, unmapped reads zero
    if (regRd) begin
      case (regAddr)
        REG_CTRL: n.regRdata = {24'h000000, r.ctrl};
        REG_NC0:  n.regRdata = {15'h0000, r.nc0};
        REG_NC1:  n.regRdata = {15'h0000, r.nc1};
        REG_BANK: n.regRdata = {28'h0000000, r.bank};
        REG_STAT: n.regRdata = {24'h000000, mif.refPend,
                                r.memReq, r.st};
        default:  n.regRdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= CTRL_RST;
      r.nc0 <= NC_RST;
      r.nc1 <= NC_RST;
      r.bank <= BANK_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign cpuRdata = r.rdata;
  assign cpuReady = r.ready;
  assign romSel = r.romSel;
  assign regRdata = r.regRdata;
endmodule // ccd_cache_ctrl
`default_nettype wire

// ===== dv/ccd_dram_model.sv
`default_nettype none
// Behavioural DRAM array standing behind both banks
module ccd_dram_model (
  input  wire logic        clk,
  input  wire logic [1:0]  rasB,
  input  wire logic [3:0]  casB,
  input  wire logic        weB,
  input  wire logic [10:0] ma,
  input  wire logic [31:0] dqOut,
  output logic [31:0]      dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [int];          // Words by bank, row and column
  logic [31:0] hold = 32'h0;       // Stale bus value, toggles when idle
  logic [12:0] row = 13'h0;        // Open bank and row
  logic [1:0]  prevRas = 2'h3;     // Row strobes one cycle back
  int          nWr = 0;            // Write cycles seen
  wire logic   cas = (casB != 4'hF) && (rasB != 2'h3);
  wire logic [23:0] key = {row, ma};
  always @* dqIn = (cas && weB && mem.exists(key)) ? mem[key] : hold;
  always @(posedge clk) begin
    prevRas <= rasB;
    if (prevRas == 2'h3 && rasB != 2'h3 && casB == 4'hF) row <= {rasB, ma};
    if (cas && !weB) begin
      mem[key] = dqOut;
      nWr++;
    end
    hold <= cas ? dqIn : ~hold;
  end
endmodule // ccd_dram_model
`default_nettype wire

// ===== dv/ccd_cache_ctrl_monitor.sv
`default_nettype none
// Port checks of the cache and DRAM controller
module ccd_cache_ctrl_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        cpuReq,
  input wire logic        cpuReady,
  input wire logic        romSel,
  input wire logic        romDone,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [1:0]  rasB,
  input wire logic [3:0]  casB,
  input wire logic        weB,
  input wire logic        dqOeB
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Refresh: rows follow columns, then all strobes release
  sequence s_cbr;
    rasB == 2'h0 ##1 (rasB == 2'h3 && casB == 4'hF);
  endsequence
  a_ready_once: assert property (cpuReady |=> !cpuReady) else $error("ready held");
  a_ready_cause: assert property (cpuReady |-> $past(cpuReq)) else $error("stray ready");
  a_ready_bound: assert property ($rose(cpuReq) |-> ##[1:400] cpuReady)
    else $error("request never answered");
  a_cas_pulse: assert property (casB != 4'hF && rasB != 2'h3 |=> casB == 4'hF)
    else $error("long cas");
  a_cbr_refresh: assert property ((casB == 4'h0 && rasB == 2'h3) |=> s_cbr)
    else $error("bad refresh");
  a_dq_write: assert property ((casB != 4'hF && rasB != 2'h3) |-> dqOeB == weB)
    else $error("bus drive");
  a_reg_quiet: assert property (!regRd |=> regRdata == 32'h0) else $error("reg data");
  a_rom_hold: assert property (romSel && !romDone |=> romSel) else $error("rom drop");
  a_rom_ready: assert property (romSel && romDone |=> cpuReady) else $error("rom ready");
endmodule // ccd_cache_ctrl_monitor
bind ccd_cache_ctrl ccd_cache_ctrl_monitor u_mon (.clk, .rst_b, .cpuReq, .cpuReady, .romSel,
  .romDone, .regRd, .regRdata, .rasB, .casB, .weB, .dqOeB);
`default_nettype wire

// ===== dv/ccd_cache_ctrl_bench.sv
`default_nettype none
// Self-checking bench of the cache and DRAM controller
module ccd_cache_ctrl_bench import ccd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, cpuReq = 1'b0, cpuWe = 1'b0, romDone = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, romSel, cpuReady, weB, dqOeB;
  logic [AW-1:0]  cpuAddr = 23'h0;
  logic [3:0]     cpuBe = 4'hF;
  logic [7:0]     regAddr = 8'h0;
  logic [31:0]    cpuWdata = 32'h0, romRdata = 32'hC0DE0001, regWdata = 32'h0, q;
  logic [31:0]    cpuRdata, regRdata, dqOut, dqIn;
  logic [1:0]     rasB;
  logic [3:0]     casB;
  logic [MAW-1:0] ma;
  int n_mismatch = 0, checked = 0, lat, w0;
  localparam logic [AW-1:0] A = 23'h000100, R = 23'h030000;
  ccd_cache_ctrl DUT (.clk, .rst_b, .cpuReq, .cpuWe, .cpuAddr, .cpuBe, .cpuWdata, .cpuRdata,
    .cpuReady, .romSel, .romDone, .romRdata, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .rasB, .casB, .weB, .ma, .dqOut, .dqOeB, .dqIn);
  ccd_dram_model mdl (.clk, .rasB, .casB, .weB, .ma, .dqOut, .dqIn);
  always #25 clk = ~clk;
  // ROM ends each cycle one clock after select
  always @(posedge clk) romDone <= romSel && !romDone;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic regw(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic regr(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
    @(posedge clk);
  endtask
  // Processor access, held until ready, with cycle count
  task automatic cpu(input logic we, input logic [AW-1:0] a, input logic [31:0] d);
    cpuReq <= 1'b1;
    cpuWe <= we;
    cpuAddr <= a;
    cpuWdata <= d;
    lat = 0;
    do begin
      @(posedge clk);
      #1 lat++;
    end while (cpuReady !== 1'b1 && lat < 400);
    if (lat >= 400) begin
      n_mismatch++;
      give_verdict();
    end
    q = cpuRdata;
    cpuReq <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    regw(REG_CTRL, 32'h13);
    regw(REG_BANK, 32'h1);
    regr(REG_CTRL, 32'h13);
    regr(8'h20, 32'h0);
    cpu(1'b1, A, 32'hA1);
    cpu(1'b0, A, 32'h0);
    chk(q, 32'hA1);
    chk(32'(lat > 1), 32'h1);
    cpu(1'b0, A, 32'h0);
    chk(q, 32'hA1);
    chk(32'(lat), 32'h1);
    w0 = mdl.nWr;
    cpu(1'b1, A, 32'hA2);
    chk(32'(lat), 32'h1);
    cpu(1'b1, A, 32'hA3);
    chk(32'(mdl.nWr - w0), 32'h0);
    cpu(1'b0, A + 23'h400, 32'h0);
    cpu(1'b0, A + 23'h800, 32'h0);
    chk(32'(mdl.nWr - w0), 32'h1);
    cpu(1'b0, A, 32'h0);
    chk(q, 32'hA3);
    regw(REG_NC0, 32'h1FF00);
    cpu(1'b0, A, 32'h0);
    cpu(1'b0, A, 32'h0);
    chk(32'(lat > 1), 32'h1);
    regw(REG_NC0, 32'h0);
    regw(REG_NC1, 32'h1FF00);
    cpu(1'b0, A, 32'h0);
    chk(32'(lat > 1), 32'h1);
    regw(REG_NC1, 32'h0);
    cpu(1'b0, R, 32'h0);
    chk(q, 32'hC0DE0001);
    regw(REG_CTRL, 32'h1B);
    cpu(1'b1, R, 32'hB4);
    cpu(1'b0, R, 32'h0);
    chk(q, 32'hB4);
    repeat (700) @(posedge clk);
    cpu(1'b0, A, 32'h0);
    chk(q, 32'hA3);
    give_verdict();
  end
endmodule // ccd_cache_ctrl_bench
`default_nettype wire
